// ### design/fpacc_defines.vh
`ifndef FPACC_DEFINES_VH
`define FPACC_DEFINES_VH

// register byte offsets within the 4 KB window
`define FPACC_ADDR_W        12
`define FPACC_OFS_PERM      12'hd88
`define FPACC_OFS_CTX       12'hf34
`define FPACC_OFS_ISTAT     12'hf40
`define FPACC_OFS_IMASK     12'hf44

// reset values
`define FPACC_PERM_RST      32'h00000000
`define FPACC_CTX_RST       32'hc0000000
`define FPACC_IMASK_RST     3'h0

// coprocessor_permission field positions
`define FPACC_SINGLE_LO     20
`define FPACC_DOUBLE_LO     22

// fp_context_control bit positions
`define FPACC_AUTO_BIT      31
`define FPACC_LAZY_EN_BIT   30
`define FPACC_MON_BIT       8
`define FPACC_BUS_BIT       6
`define FPACC_MEM_BIT       5
`define FPACC_ESC_BIT       4
`define FPACC_THREAD_BIT    3
`define FPACC_USER_BIT      1
`define FPACC_LAZY_ACT_BIT  0

// permission field encodings
`define FPACC_PERM_DENY     2'b00
`define FPACC_PERM_PRIV     2'b01
`define FPACC_PERM_RSVD     2'b10
`define FPACC_PERM_FULL     2'b11

// floating-point coprocessor numbers
`define FPACC_CP_SINGLE     4'ha
`define FPACC_CP_DOUBLE     4'hb

// interrupt status and mask layout
`define FPACC_IRQ_W         3
`define FPACC_IRQ_FAULT     0
`define FPACC_IRQ_ALLOC     1
`define FPACC_IRQ_SAVE      2

// AXI responses
`define FPACC_RESP_OKAY     2'b00
`define FPACC_RESP_SLVERR   2'b10

`endif

// ### design/fpacc_perm_check.v
`timescale 1ns/100ps
`include "fpacc_defines.vh"

module fpacc_perm_check (
	input  wire [1:0] perm,
	input  wire       req,
	input  wire       priv,
	output reg        grant,
	output reg        fault
);

	always @* begin
		grant = 1'b0;
		fault = 1'b0;
		if (req) begin
			case (perm)
				`FPACC_PERM_DENY: fault = 1'b1;
				`FPACC_PERM_PRIV: begin
					grant = priv;
					fault = ~priv;
				end
				`FPACC_PERM_FULL: grant = 1'b1;
				// reserved code: deny, the safest of the unpredictable outcomes
				default: fault = 1'b1;
			endcase
		end
	end

endmodule // fpacc_perm_check

// ### design/fpacc_top.v
// Operation
// - access-control bits 31:24 and 19:0 read as zero and ignore writes.
// - coprocessor n has a two-bit permission field at bits 2n+1:2n, for n of 10 (21:20) and 11 (23:22).
// - permission 0b00 denies every access and raises a no-coprocessor usage fault.
// - permission 0b01 allows privileged access and faults any unprivileged one.
// - permission 0b11 gives full access; 0b10 is reserved and software must not program it.
// - with context bit 31 set a floating-point instruction sets the context-active flag; with it clear it does not.
// - context bit 30 enables lazy preservation when set and disables it when clear.
// - at frame allocation bit 8 captures whether the debug monitor was enabled and could be pended.
// - at frame allocation bit 6 captures whether the bus error exception could be pended.
// - at frame allocation bit 5 captures whether the memory protection exception could be pended.
// - at frame allocation bit 4 captures whether the escalated fault handler could be pended.
// - at frame allocation bit 3 records whether the processor was in thread mode.
// - at frame allocation bit 1 records whether execution was unprivileged.
// - bit 0 is set while a frame is allocated with its save deferred and clear when lazy saving is idle.
// - the context register resets to 0xc0000000, both preservation enables on and status clear.
`timescale 1ns/100ps
`include "fpacc_defines.vh"

module fpacc_top (
	input  wire                      aclk,
	input  wire                      aresetn,
	// AXI4-Lite slave
	input  wire                      s_axi_awvalid,
	output wire                      s_axi_awready,
	input  wire [`FPACC_ADDR_W-1:0]  s_axi_awaddr,
	input  wire [2:0]                s_axi_awprot,
	input  wire                      s_axi_wvalid,
	output wire                      s_axi_wready,
	input  wire [31:0]               s_axi_wdata,
	input  wire [3:0]                s_axi_wstrb,
	output wire                      s_axi_bvalid,
	input  wire                      s_axi_bready,
	output wire [1:0]                s_axi_bresp,
	input  wire                      s_axi_arvalid,
	output wire                      s_axi_arready,
	input  wire [`FPACC_ADDR_W-1:0]  s_axi_araddr,
	input  wire [2:0]                s_axi_arprot,
	output wire                      s_axi_rvalid,
	input  wire                      s_axi_rready,
	output wire [31:0]               s_axi_rdata,
	output wire [1:0]                s_axi_rresp,
	// core side
	input  wire                      cp_req_valid,
	input  wire [3:0]                cp_req_num,
	input  wire                      cp_req_priv,
	output wire                      cp_grant,
	output wire                      no_coprocessor_fault,
	input  wire                      fp_instr_exec,
	input  wire                      fp_context_clear,
	output wire                      fp_context_active_flag,
	input  wire                      frame_alloc,
	input  wire                      debug_monitor_ready,
	input  wire                      bus_error_ready,
	input  wire                      mem_protect_ready,
	input  wire                      escalated_fault_ready,
	input  wire                      thread_mode,
	input  wire                      user_level,
	output wire                      lazy_preserve_active,
	output wire                      auto_preserve_enable,
	output wire                      lazy_preserve_enable,
	output wire                      lazy_save_start,
	output wire                      irq
);

	localparam [31:0] PERM_RST = `FPACC_PERM_RST;
	localparam [31:0] CTX_RST  = `FPACC_CTX_RST;

	function [31:0] merge_strb;
		input [31:0] old_val;
		input [31:0] new_val;
		input [3:0]  strb;
		integer      i;
		begin
			merge_strb = old_val;
			for (i = 0; i < 4; i = i + 1) begin
				if (strb[i])
					merge_strb[i*8 +: 8] = new_val[i*8 +: 8];
			end
		end
	endfunction

	function mapped;
		input [`FPACC_ADDR_W-1:0] a;
		begin
			mapped = (a == `FPACC_OFS_PERM) || (a == `FPACC_OFS_CTX) ||
				(a == `FPACC_OFS_ISTAT) || (a == `FPACC_OFS_IMASK);
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// state

	reg  [1:0]               fp_single_permission_r;
	reg  [1:0]               fp_double_permission_r;
	reg                      auto_preserve_enable_r;
	reg                      lazy_preserve_enable_r;
	reg                      debug_monitor_ready_r;
	reg                      bus_error_ready_r;
	reg                      mem_protect_ready_r;
	reg                      escalated_fault_ready_r;
	reg                      thread_r;
	reg                      user_r;
	reg                      lazy_preserve_active_r;
	reg                      fp_context_active_flag_r;
	reg                      cp_grant_r;
	reg                      no_coprocessor_fault_r;
	reg                      lazy_save_start_r;
	reg  [`FPACC_IRQ_W-1:0]  irq_status_r;
	reg  [`FPACC_IRQ_W-1:0]  irq_mask_r;
	reg                      irq_r;

	reg                      aw_held_r;
	reg  [`FPACC_ADDR_W-1:0] aw_addr_r;
	reg                      aw_priv_r;
	reg                      w_held_r;
	reg  [31:0]              w_data_r;
	reg  [3:0]               w_strb_r;
	reg                      bvalid_r;
	reg  [1:0]               bresp_r;
	reg                      rvalid_r;
	reg  [31:0]              rdata_r;
	reg  [1:0]               rresp_r;

	wire [31:0]              perm_word;
	wire [31:0]              ctx_word;
	wire                     wr_fire;
	wire                     wr_ok;
	wire                     rd_fire;
	wire                     rd_ok;
	wire [31:0]              perm_merged;
	wire [31:0]              ctx_merged;
	wire [31:0]              mask_merged;
	wire [1:0]               sel_perm;
	wire                     is_fp_cp;
	wire                     chk_grant;
	wire                     chk_fault;
	wire                     cp_fault_event;
	wire                     save_event;
	reg  [`FPACC_IRQ_W-1:0]  irq_status_nxt;
	reg  [31:0]              rd_word;

	////////////////////////////////////////////////////////////////////////////
	// register images

	// only the two permission fields exist; everything else is constant zero
	assign perm_word = {8'h00, fp_double_permission_r, fp_single_permission_r, 20'h00000};

	assign ctx_word = {auto_preserve_enable_r, lazy_preserve_enable_r, 21'h0,
		debug_monitor_ready_r, 1'b0, bus_error_ready_r, mem_protect_ready_r,
		escalated_fault_ready_r, thread_r, 1'b0, user_r, lazy_preserve_active_r};

	////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite write path: address and data accepted in either order

	assign wr_fire     = aw_held_r && w_held_r && !bvalid_r;
	// unprivileged bus accesses are refused with an error and change nothing
	assign wr_ok       = mapped(aw_addr_r) && aw_priv_r;
	assign perm_merged = merge_strb(perm_word, w_data_r, w_strb_r);
	assign ctx_merged  = merge_strb(ctx_word, w_data_r, w_strb_r);
	assign mask_merged = merge_strb({{(32-`FPACC_IRQ_W){1'b0}}, irq_mask_r}, w_data_r, w_strb_r);

	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_r <= 1'b0;
			aw_addr_r <= {`FPACC_ADDR_W{1'b0}};
			aw_priv_r <= 1'b0;
			w_held_r  <= 1'b0;
			w_data_r  <= 32'h00000000;
			w_strb_r  <= 4'h0;
			bvalid_r  <= 1'b0;
			bresp_r   <= `FPACC_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && !aw_held_r) begin
				aw_held_r <= 1'b1;
				aw_addr_r <= s_axi_awaddr;
				aw_priv_r <= s_axi_awprot[0];
			end
			if (s_axi_wvalid && !w_held_r) begin
				w_held_r <= 1'b1;
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_held_r <= 1'b0;
				w_held_r  <= 1'b0;
				bvalid_r  <= 1'b1;
				bresp_r   <= wr_ok ? `FPACC_RESP_OKAY : `FPACC_RESP_SLVERR;
			end else if (bvalid_r && s_axi_bready) begin
				bvalid_r <= 1'b0;
			end
		end
	end

	assign s_axi_awready = !aw_held_r;
	assign s_axi_wready  = !w_held_r;
	assign s_axi_bvalid  = bvalid_r;
	assign s_axi_bresp   = bresp_r;

	////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite read path

	assign rd_fire = s_axi_arvalid && !rvalid_r;
	assign rd_ok   = mapped(s_axi_araddr) && s_axi_arprot[0];

	always @* begin
		rd_word = 32'h00000000;
		case (s_axi_araddr)
			`FPACC_OFS_PERM:  rd_word = perm_word;
			`FPACC_OFS_CTX:   rd_word = ctx_word;
			`FPACC_OFS_ISTAT: rd_word = {{(32-`FPACC_IRQ_W){1'b0}}, irq_status_r};
			`FPACC_OFS_IMASK: rd_word = {{(32-`FPACC_IRQ_W){1'b0}}, irq_mask_r};
			default:          rd_word = 32'h00000000;
		endcase
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_r <= 1'b0;
			rdata_r  <= 32'h00000000;
			rresp_r  <= `FPACC_RESP_OKAY;
		end else if (rd_fire) begin
			rvalid_r <= 1'b1;
			rdata_r  <= rd_ok ? rd_word : 32'h00000000;
			rresp_r  <= rd_ok ? `FPACC_RESP_OKAY : `FPACC_RESP_SLVERR;
		end else if (rvalid_r && s_axi_rready) begin
			rvalid_r <= 1'b0;
		end
	end

	assign s_axi_arready = !rvalid_r;
	assign s_axi_rvalid  = rvalid_r;
	assign s_axi_rdata   = rdata_r;
	assign s_axi_rresp   = rresp_r;

	////////////////////////////////////////////////////////////////////////////
	// coprocessor access check

	assign is_fp_cp = (cp_req_num == `FPACC_CP_SINGLE) || (cp_req_num == `FPACC_CP_DOUBLE);
	assign sel_perm = (cp_req_num == `FPACC_CP_DOUBLE) ? fp_double_permission_r : fp_single_permission_r;

	fpacc_perm_check i_fpacc_perm_check (
		.perm  (sel_perm),
		.req   (cp_req_valid && is_fp_cp),
		.priv  (cp_req_priv),
		.grant (chk_grant),
		.fault (chk_fault)
	);

	// any other coprocessor number does not exist here and always faults
	assign cp_fault_event = chk_fault || (cp_req_valid && !is_fp_cp);

	always @(posedge aclk) begin
		if (!aresetn) begin
			cp_grant_r             <= 1'b0;
			no_coprocessor_fault_r <= 1'b0;
		end else begin
			cp_grant_r             <= chk_grant;
			no_coprocessor_fault_r <= cp_fault_event;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// configuration and context capture

	assign save_event = fp_instr_exec && lazy_preserve_active_r && !frame_alloc;

	always @(posedge aclk) begin
		if (!aresetn) begin
			fp_single_permission_r <= PERM_RST[`FPACC_SINGLE_LO +: 2];
			fp_double_permission_r <= PERM_RST[`FPACC_DOUBLE_LO +: 2];
			auto_preserve_enable_r <= CTX_RST[`FPACC_AUTO_BIT];
			lazy_preserve_enable_r <= CTX_RST[`FPACC_LAZY_EN_BIT];
			irq_mask_r             <= `FPACC_IMASK_RST;
		end else if (wr_fire && wr_ok) begin
			case (aw_addr_r)
				`FPACC_OFS_PERM: begin
					fp_single_permission_r <= perm_merged[`FPACC_SINGLE_LO +: 2];
					fp_double_permission_r <= perm_merged[`FPACC_DOUBLE_LO +: 2];
				end
				`FPACC_OFS_CTX: begin
					auto_preserve_enable_r <= ctx_merged[`FPACC_AUTO_BIT];
					lazy_preserve_enable_r <= ctx_merged[`FPACC_LAZY_EN_BIT];
				end
				`FPACC_OFS_IMASK: irq_mask_r <= mask_merged[`FPACC_IRQ_W-1:0];
				default: ;
			endcase
		end
	end

	// status fields are owned by the capture logic; software writes do not reach them
	always @(posedge aclk) begin
		if (!aresetn) begin
			debug_monitor_ready_r   <= 1'b0;
			bus_error_ready_r       <= 1'b0;
			mem_protect_ready_r     <= 1'b0;
			escalated_fault_ready_r <= 1'b0;
			thread_r                <= 1'b0;
			user_r                  <= 1'b0;
			lazy_preserve_active_r  <= 1'b0;
			lazy_save_start_r       <= 1'b0;
		end else begin
			lazy_save_start_r <= save_event;
			if (frame_alloc) begin
				debug_monitor_ready_r   <= debug_monitor_ready;
				bus_error_ready_r       <= bus_error_ready;
				mem_protect_ready_r     <= mem_protect_ready;
				escalated_fault_ready_r <= escalated_fault_ready;
				thread_r                <= thread_mode;
				user_r                  <= user_level;
				// without lazy mode the core saves at once, so nothing stays deferred
				lazy_preserve_active_r  <= lazy_preserve_enable_r;
			end else if (save_event) begin
				lazy_preserve_active_r  <= 1'b0;
			end
		end
	end

	// set wins over the core's clear so an fp instruction in that cycle is kept
	always @(posedge aclk) begin
		if (!aresetn)
			fp_context_active_flag_r <= 1'b0;
		else if (fp_instr_exec && auto_preserve_enable_r)
			fp_context_active_flag_r <= 1'b1;
		else if (fp_context_clear)
			fp_context_active_flag_r <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////
	// interrupt status: sticky, cleared by reading, events win over the clear

	always @* begin
		irq_status_nxt = irq_status_r;
		if (rd_fire && rd_ok && (s_axi_araddr == `FPACC_OFS_ISTAT))
			irq_status_nxt = {`FPACC_IRQ_W{1'b0}};
		irq_status_nxt[`FPACC_IRQ_FAULT] = irq_status_nxt[`FPACC_IRQ_FAULT] | cp_fault_event;
		irq_status_nxt[`FPACC_IRQ_ALLOC] = irq_status_nxt[`FPACC_IRQ_ALLOC] | frame_alloc;
		irq_status_nxt[`FPACC_IRQ_SAVE]  = irq_status_nxt[`FPACC_IRQ_SAVE] | save_event;
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			irq_status_r <= {`FPACC_IRQ_W{1'b0}};
			irq_r        <= 1'b0;
		end else begin
			irq_status_r <= irq_status_nxt;
			// registered from the next values so irq tracks status without lag
			irq_r        <= |(irq_status_nxt & irq_mask_r);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs

	assign cp_grant               = cp_grant_r;
	assign no_coprocessor_fault   = no_coprocessor_fault_r;
	assign fp_context_active_flag = fp_context_active_flag_r;
	assign lazy_preserve_active   = lazy_preserve_active_r;
	assign auto_preserve_enable   = auto_preserve_enable_r;
	assign lazy_preserve_enable   = lazy_preserve_enable_r;
	assign lazy_save_start        = lazy_save_start_r;
	assign irq                    = irq_r;

endmodule // fpacc_top

// ### verif/fpacc_props.sv
`timescale 1ns/100ps
module fpacc_props (
	input wire        aclk,
	input wire        aresetn,
	input wire        cp_req_valid,
	input wire        cp_grant,
	input wire        no_coprocessor_fault,
	input wire        fp_instr_exec,
	input wire        frame_alloc,
	input wire        fp_context_active_flag,
	input wire        auto_preserve_enable,
	input wire        lazy_preserve_enable,
	input wire        lazy_preserve_active,
	input wire        lazy_save_start,
	input wire        s_axi_arvalid,
	input wire        s_axi_arready,
	input wire        s_axi_rvalid,
	input wire        s_axi_rready,
	input wire [31:0] s_axi_rdata
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
////////////////////////////////////////
	a_cp_answer: assert property (cp_req_valid |=> cp_grant ^ no_coprocessor_fault)
		else $error("request without exactly one answer");
	a_cp_quiet: assert property (!cp_req_valid |=> !cp_grant && !no_coprocessor_fault)
		else $error("answer without request");
	a_flag_set: assert property (fp_instr_exec && auto_preserve_enable |=> fp_context_active_flag)
		else $error("context flag not set");
	a_flag_cause: assert property ($rose(fp_context_active_flag) |-> $past(fp_instr_exec && auto_preserve_enable))
		else $error("context flag rose without cause");
	a_lazy_arm: assert property (frame_alloc && lazy_preserve_enable |=> lazy_preserve_active)
		else $error("deferred save not armed");
	a_lazy_off: assert property (frame_alloc && !lazy_preserve_enable |=> !lazy_preserve_active)
		else $error("deferred save armed while disabled");
	a_lazy_hold: assert property (lazy_preserve_active && !fp_instr_exec && !frame_alloc |=> lazy_preserve_active)
		else $error("deferred save dropped early");
	a_save_start: assert property (fp_instr_exec && !frame_alloc && lazy_preserve_active
		|=> lazy_save_start && !lazy_preserve_active)
		else $error("deferred save not started");
	a_save_cause: assert property (lazy_save_start |-> $past(fp_instr_exec && lazy_preserve_active))
		else $error("save start without cause");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data not held");
endmodule // fpacc_props
////////////////////////////////////////
bind fpacc_top fpacc_props i_fpacc_props (.*);

// ### verif/fpacc_core_model.sv
`timescale 1ns/100ps
module fpacc_core_model (
	input  wire       aclk,
	input  wire       lazy_save_start,
	output reg        cp_req_valid = 1'b0,
	output reg  [3:0] cp_req_num   = 4'h0,
	output reg        cp_req_priv  = 1'b0,
	output reg        fp_instr_exec = 1'b0,
	output reg        fp_context_clear = 1'b0,
	output reg        frame_alloc  = 1'b0,
	output reg  [5:0] ready_lvls   = 6'h00
);
	int saves = 0;
	// kind is {request, privileged, fp instruction, flag clear, frame alloc}
	task automatic op(input [3:0] num, input [4:0] kind, input [5:0] rdy);
		@(posedge aclk);
		{cp_req_valid, cp_req_priv, fp_instr_exec, fp_context_clear, frame_alloc} <= kind;
		cp_req_num <= num;
		ready_lvls <= rdy;
		@(posedge aclk);
		{cp_req_valid, fp_instr_exec, fp_context_clear, frame_alloc} <= 4'h0;
		// idle lines move so a stale capture cannot pass
		cp_req_num <= ~num;
		ready_lvls <= ~rdy;
	endtask
	always @(posedge aclk) begin
		if (lazy_save_start)
			saves <= saves + 1;
	end
endmodule // fpacc_core_model

// ### verif/fpacc_top_bench.sv
`timescale 1ns/100ps
`include "fpacc_defines.vh"
module fpacc_top_bench;
	reg         aclk = 1'b0;
	reg         aresetn = 1'b0;
	reg         s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	reg         s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	reg  [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
	reg  [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
	reg  [31:0] s_axi_wdata = 32'h0;
	reg  [3:0]  s_axi_wstrb = 4'hf;
	wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire [1:0]  s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire        cp_req_valid, cp_req_priv, fp_instr_exec, fp_context_clear, frame_alloc;
	wire [3:0]  cp_req_num;
	wire [5:0]  ready_lvls;
	wire        debug_monitor_ready, bus_error_ready, mem_protect_ready;
	wire        escalated_fault_ready, thread_mode, user_level;
	wire        cp_grant, no_coprocessor_fault, fp_context_active_flag, lazy_preserve_active;
	wire        auto_preserve_enable, lazy_preserve_enable, lazy_save_start, irq;
	int         fails = 0, checks_done = 0, i;
	reg  [1:0]  r;
	reg  [31:0] d, pv;
	reg  [5:0]  rdy;
	reg  [3:0]  num;
	reg         priv;
	// software never programs the reserved 0b10 code
	localparam [5:0] CODES = 6'b11_01_00;
	assign {debug_monitor_ready, bus_error_ready, mem_protect_ready,
		escalated_fault_ready, thread_mode, user_level} = ready_lvls;
	fpacc_top i_fpacc_top (.*);
	fpacc_core_model i_fpacc_core_model (.*);
	always #2 aclk = ~aclk;
////////////////////////////////////////
	function automatic [1:0] exp_cp(input [31:0] pr, input [3:0] n, input p);
		reg [1:0] f;
		f = (n == 4'ha) ? pr[21:20] : (n == 4'hb) ? pr[23:22] : 2'b00;
		exp_cp = (f == 2'b11 || (f == 2'b01 && p)) ? 2'b10 : 2'b01;
	endfunction
	function automatic [31:0] exp_ctx(input [1:0] en, input [5:0] c, input lz);
		exp_ctx = {en, 21'h0, c[5], 1'b0, c[4:1], 1'b0, c[0], lz};
	endfunction
	task automatic chk(input [31:0] got, input [31:0] exp, input string what);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
////////////////////////////////////////
	task automatic axw(input [11:0] a, input [31:0] dt, input [2:0] p, output [1:0] rs);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_awprot <= p;
		s_axi_wdata <= dt;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		// only the watchdog ends a wait
		do begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		rs = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic axr(input [11:0] a, input [2:0] p, output [31:0] dt, output [1:0] rs);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arprot <= p;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		dt = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	task automatic wr(input [11:0] a, input [31:0] dt);
		reg [1:0] rs;
		axw(a, dt, 3'h1, rs);
		chk(rs, `FPACC_RESP_OKAY, "bresp");
	endtask
	task automatic rdchk(input [11:0] a, input [31:0] exp);
		reg [1:0]  rs;
		reg [31:0] dt;
		axr(a, 3'h1, dt, rs);
		chk(rs, `FPACC_RESP_OKAY, "rresp");
		chk(dt, exp, "rdata");
	endtask
	task automatic core(input [3:0] n, input [4:0] k, input [5:0] c);
		i_fpacc_core_model.op(n, k, c);
		#1;
	endtask
////////////////////////////////////////
	initial begin
		#100000;
		fails++;
		print_verdict;
	end
	initial begin
		void'($urandom(32'hdd83cca8));
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		rdchk(`FPACC_OFS_PERM, 32'h0);
		rdchk(`FPACC_OFS_CTX, 32'hc0000000);
		chk({auto_preserve_enable, lazy_preserve_enable}, 2'b11, "enables");
		$display("test reset done");
		wr(`FPACC_OFS_PERM, 32'hffffffff);
		rdchk(`FPACC_OFS_PERM, 32'h00f00000);
		axw(`FPACC_OFS_PERM, 32'h0, 3'h0, r);
		chk(r, `FPACC_RESP_SLVERR, "unprivileged write");
		// lane 2 masked: a landed refused write or an ignored strobe both read back zero
		s_axi_wstrb <= 4'hb;
		wr(`FPACC_OFS_PERM, 32'h0);
		rdchk(`FPACC_OFS_PERM, 32'h00f00000);
		s_axi_wstrb <= 4'hf;
		axr(`FPACC_OFS_PERM, 3'h0, d, r);
		chk(r, `FPACC_RESP_SLVERR, "unprivileged read");
		chk(d, 32'h0, "unprivileged rdata");
		axr(12'h004, 3'h1, d, r);
		chk(r, `FPACC_RESP_SLVERR, "unmapped read");
		for (i = 0; i < 36; i++) begin
			pv = {8'h0, CODES[2*((i/3)%3)+:2], CODES[2*(i%3)+:2], 20'h0};
			wr(`FPACC_OFS_PERM, pv | ($urandom & 32'hff0fffff));
			rdchk(`FPACC_OFS_PERM, pv);
			num = (i % 9 == 8) ? 4'h3 : 4'ha + 4'($urandom % 2);
			priv = 1'($urandom);
			core(num, {1'b1, priv, 3'b000}, 6'($urandom));
			chk({cp_grant, no_coprocessor_fault}, exp_cp(pv, num, priv), "cp answer");
		end
		$display("test permission done");
		wr(`FPACC_OFS_CTX, 32'h0);
		rdchk(`FPACC_OFS_CTX, 32'h0);
		rdy = 6'($urandom);
		core(4'h0, 5'b00001, rdy);
		chk(lazy_preserve_active, 1'b0, "lazy off");
		rdchk(`FPACC_OFS_CTX, exp_ctx(2'b00, rdy, 1'b0));
		core(4'h0, 5'b00100, 6'h0);
		chk(fp_context_active_flag, 1'b0, "flag off");
		wr(`FPACC_OFS_CTX, 32'hffffffff);
		rdchk(`FPACC_OFS_CTX, exp_ctx(2'b11, rdy, 1'b0));
		core(4'h0, 5'b00100, 6'h0);
		chk(fp_context_active_flag, 1'b1, "flag on");
		core(4'h0, 5'b00110, 6'h0);
		chk(fp_context_active_flag, 1'b1, "set beats clear");
		core(4'h0, 5'b00010, 6'h0);
		chk(fp_context_active_flag, 1'b0, "flag cleared");
		for (i = 0; i < 4; i++) begin
			rdy = 6'($urandom);
			core(4'h0, 5'b00001, rdy);
			chk(lazy_preserve_active, 1'b1, "lazy armed");
			rdchk(`FPACC_OFS_CTX, exp_ctx(2'b11, rdy, 1'b1));
			core(4'h0, 5'b00100, 6'h0);
			chk({lazy_save_start, lazy_preserve_active}, 2'b10, "save start");
		end
		// the model counts the last pulse on the edge after it
		@(posedge aclk);
		#1;
		chk(i_fpacc_core_model.saves, 4, "save count");
		$display("test context done");
		// fault, allocation and save events have all occurred by now
		rdchk(`FPACC_OFS_ISTAT, 32'h7);
		wr(`FPACC_OFS_IMASK, 32'h0);
		core(4'h3, 5'b10000, 6'h0);
		chk(irq, 1'b0, "masked irq");
		wr(`FPACC_OFS_IMASK, 32'h1);
		repeat (2) @(posedge aclk);
		#1;
		chk(irq, 1'b1, "irq raised");
		rdchk(`FPACC_OFS_IMASK, 32'h1);
		rdchk(`FPACC_OFS_ISTAT, 32'h1);
		@(posedge aclk);
		#1;
		chk(irq, 1'b0, "irq cleared");
		$display("test interrupt done");
		print_verdict;
	end
endmodule // fpacc_top_bench
